// ### logic/cca_consts.vh
// Functional notes
// - 16 channels; resolution one clock, eight clocks when staggered.
// - Two independent 16-bit timers, each with its own reload register.
// - Timer clock: prescaled system clock or external period timer overflow.
// - Timers may also count edges on external count inputs.
// - 16 channel registers, each picks a timer and capture or compare.
// - Each channel owns one pin: capture input or compare output.
// - Capture copies the assigned timer value into the channel register.
// - Each capture raises that channel's own interrupt request.
// - Capture trigger per channel: rising, falling or both edges.
// - Compare channels compare continuously; a match runs the mode action.
// - Mode 0: interrupt only, several per period, pin untouched.
// - Mode 1: pin toggles on every match, several per period.
// - Mode 2: interrupt only, at most one per timer period.
// - Mode 3: pin high on match, low on timer overflow; one per period.
// - Double register: two channels toggle one shared pin.
// - Single-event option yields just one edge or pulse, any compare mode.
`ifndef CCA_CONSTS_VH
`define CCA_CONSTS_VH

`define CCA_CNT0        8'h00
`define CCA_RELOAD0     8'h04
`define CCA_CNT1        8'h08
`define CCA_RELOAD1     8'h0C
`define CCA_TCTRL       8'h10
`define CCA_STATUS      8'h14
`define CCA_IRQ_EN      8'h18
`define CCA_IRQ_CLR     8'h1C
`define CCA_DOUBLE      8'h20
`define CCA_PINS        8'h24
`define CCA_CHVAL_PAGE  2'h1
`define CCA_CHCTL_PAGE  2'h2

`define CCA_T0_SEL_LSB  0
`define CCA_T1_SEL_LSB  4
`define CCA_STAGGER     8
`define CCA_STAGGER_SH  3
`define CCA_TCTRL_RST   16'h0077

`define CCA_SEL_PERIOD  3'h5
`define CCA_SEL_PIN     3'h6
`define CCA_SEL_STOP    3'h7

`define CCA_CH_RISE     3
`define CCA_CH_FALL     4
`define CCA_CH_TSEL     5
`define CCA_CH_SINGLE   6
`define CCA_FN_OFF      3'h0
`define CCA_FN_CAP      3'h1
`define CCA_FN_M0       3'h2
`define CCA_FN_M1       3'h3
`define CCA_FN_M2       3'h4
`define CCA_FN_M3       3'h5

`define CCA_RESP_OKAY   2'h0
`define CCA_RESP_SLVERR 2'h2

`endif

// ### logic/pin_sync.v
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 18
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] raw,
  output reg  [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  reg [W-1:0] meta;
  reg [W-1:0] prev;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta  <= {W{1'b0}};
      level <= {W{1'b0}};
      prev  <= {W{1'b0}};
    end
    else
    begin
      meta  <= raw;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule // pin_sync

// ### logic/time_base.v
`timescale 1ns/1ps
`include "cca_consts.vh"
module time_base (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [2:0]  sel,
  input  wire        stagger,
  input  wire        period_ovf,
  input  wire        pin_edge,
  input  wire [15:0] reload,
  input  wire        ld,
  input  wire [15:0] ld_val,
  output reg  [15:0] cnt,
  output reg         ovf,
  output reg         fresh
);
  reg  [6:0] pre;
  wire [2:0] shift = sel + (stagger ? 3'd`CCA_STAGGER_SH : 3'd0);
  wire [6:0] mask  = (7'h01 << shift) - 7'h01;
  reg        tick;

  always @*
  begin
    case (sel)
      `CCA_SEL_PERIOD: tick = period_ovf;
      `CCA_SEL_PIN:    tick = pin_edge;
      `CCA_SEL_STOP:   tick = 1'b0;
      default:         tick = (pre & mask) == mask;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre   <= 7'h00;
      cnt   <= 16'h0000;
      ovf   <= 1'b0;
      fresh <= 1'b0;
    end
    else
    begin
      pre   <= pre + 7'h01;
      ovf   <= 1'b0;
      fresh <= ld | tick;
      if (ld)
        cnt <= ld_val;
      else if (tick)
      begin
        if (cnt == 16'hFFFF)
        begin
          cnt <= reload;
          ovf <= 1'b1;
        end
        else
          cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule // time_base

// ### logic/capture_compare_array.v
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "cca_consts.vh"
module capture_compare_array (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire [15:0] pin_in,
  output reg  [15:0] pin_out,
  output reg  [15:0] pin_oe,
  input  wire [1:0]  count_pin,
  input  wire        ext_period_ovf,
  output wire        irq
);
  integer i;
  integer j;
  integer k;
  integer p;

  reg  [15:0] reload0;
  reg  [15:0] reload1;
  reg  [15:0] tctrl;
  reg  [17:0] status;
  reg  [17:0] irq_en;
  reg  [7:0]  dbl_en;
  reg  [15:0] chval [0:15];
  reg  [6:0]  chctl [0:15];
  reg  [15:0] spent;
  reg  [15:0] done;

  reg         aw_hold;
  reg         w_hold;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;

  wire [15:0] cnt0;
  wire [15:0] cnt1;
  wire [1:0]  ovf;
  wire [1:0]  fresh;
  wire [17:0] level;
  wire [17:0] rise;
  wire [17:0] fall;

  reg  [15:0] cap;
  reg  [15:0] hit;
  reg  [15:0] next_pin;
  reg  [2:0]  fn;
  reg         tsel;
  reg  [31:0] rd_word;

  function [31:0] byte_mask;
    input [3:0] strb;
    begin
      byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    reg   [31:0] m;
    begin
      m = byte_mask(strb);
      merge16 = (old & ~m[15:0]) | (data[15:0] & m[15:0]);
    end
  endfunction

  function [15:0] cnt_of;
    input        t;
    input [15:0] c0;
    input [15:0] c1;
    begin
      cnt_of = t ? c1 : c0;
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) &&
               ((a <= `CCA_PINS) || (a[7:6] == `CCA_CHVAL_PAGE) ||
                (a[7:6] == `CCA_CHCTL_PAGE));
    end
  endfunction

  function is_cmp;
    input [2:0] f;
    begin
      is_cmp = (f >= `CCA_FN_M0) && (f <= `CCA_FN_M3);
    end
  endfunction

  function once_per_period;
    input [2:0] f;
    begin
      once_per_period = (f == `CCA_FN_M2) || (f == `CCA_FN_M3);
    end
  endfunction

  function drives_pin;
    input [2:0] f;
    begin
      drives_pin = (f == `CCA_FN_M1) || (f == `CCA_FN_M3);
    end
  endfunction

  // AXI4-Lite write: address and data latched independently
  wire        do_wr   = aw_hold & w_hold & ~bvalid;
  wire [7:0]  wa      = awaddr_q;
  wire [3:0]  widx    = wa[5:2];
  wire        wr_ok   = do_wr & mapped(wa);
  wire        wr_val  = wr_ok & (wa[7:6] == `CCA_CHVAL_PAGE);
  wire        wr_ctl  = wr_ok & (wa[7:6] == `CCA_CHCTL_PAGE);
  wire [31:0] wmask   = byte_mask(wstrb_q);
  wire [17:0] clr     = (wr_ok && wa == `CCA_IRQ_CLR) ? (wdata_q[17:0] & wmask[17:0]) : 18'h00000;

  assign awready = ~aw_hold & ~bvalid;
  assign wready  = ~w_hold & ~bvalid;
  assign arready = ~rvalid;
  assign irq     = |(status & irq_en);

  time_base u_time0 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sel        (tctrl[`CCA_T0_SEL_LSB +: 3]),
    .stagger    (tctrl[`CCA_STAGGER]),
    .period_ovf (ext_period_ovf),
    .pin_edge   (rise[16]),
    .reload     (reload0),
    .ld         (wr_ok && wa == `CCA_CNT0),
    .ld_val     (merge16(cnt0, wdata_q, wstrb_q)),
    .cnt        (cnt0),
    .ovf        (ovf[0]),
    .fresh      (fresh[0])
  );

  time_base u_time1 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sel        (tctrl[`CCA_T1_SEL_LSB +: 3]),
    .stagger    (tctrl[`CCA_STAGGER]),
    .period_ovf (ext_period_ovf),
    .pin_edge   (rise[17]),
    .reload     (reload1),
    .ld         (wr_ok && wa == `CCA_CNT1),
    .ld_val     (merge16(cnt1, wdata_q, wstrb_q)),
    .cnt        (cnt1),
    .ovf        (ovf[1]),
    .fresh      (fresh[1])
  );

  pin_sync #(
    .W (18)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     ({count_pin, pin_in}),
    .level   (level),
    .rise    (rise),
    .fall    (fall)
  );

  // per-channel events and pin next state
  always @*
  begin
    cap      = 16'h0000;
    hit      = 16'h0000;
    next_pin = pin_out;
    fn       = `CCA_FN_OFF;
    tsel     = 1'b0;
    p        = 0;
    for (i = 0; i < 16; i = i + 1)
    begin
      fn   = chctl[i][2:0];
      tsel = chctl[i][`CCA_CH_TSEL];
      p    = (i >= 8 && dbl_en[i-8]) ? i - 8 : i;
      if (fn == `CCA_FN_CAP)
        cap[i] = (chctl[i][`CCA_CH_RISE] & rise[i]) |
                 (chctl[i][`CCA_CH_FALL] & fall[i]);
      hit[i] = is_cmp(fn) && fresh[tsel] &&
               (cnt_of(tsel, cnt0, cnt1) == chval[i]) &&
               !spent[i] &&
               !(once_per_period(fn) && done[i]);
      if (hit[i] && fn == `CCA_FN_M1)
        next_pin[p] = ~next_pin[p];
      if (fn == `CCA_FN_M3 && ovf[tsel])
        next_pin[p] = 1'b0;
      if (hit[i] && fn == `CCA_FN_M3)
        next_pin[p] = 1'b1;
    end
  end

  // output enable: only toggling and set/reset modes own the pin
  always @*
  begin
    pin_oe = 16'h0000;
    for (j = 0; j < 16; j = j + 1)
    begin
      if (j < 8)
        pin_oe[j] = drives_pin(chctl[j][2:0]) |
                    (dbl_en[j] & drives_pin(chctl[j+8][2:0]));
      else
        pin_oe[j] = drives_pin(chctl[j][2:0]) & ~dbl_en[j-8];
    end
  end

  always @*
  begin
    rd_word = 32'h00000000;
    case (araddr)
      `CCA_CNT0:    rd_word = {16'h0000, cnt0};
      `CCA_RELOAD0: rd_word = {16'h0000, reload0};
      `CCA_CNT1:    rd_word = {16'h0000, cnt1};
      `CCA_RELOAD1: rd_word = {16'h0000, reload1};
      `CCA_TCTRL:   rd_word = {16'h0000, tctrl};
      `CCA_STATUS:  rd_word = {14'h0000, status};
      `CCA_IRQ_EN:  rd_word = {14'h0000, irq_en};
      `CCA_DOUBLE:  rd_word = {24'h000000, dbl_en};
      `CCA_PINS:    rd_word = {pin_out, level[15:0]};
      default:
      begin
        if (araddr[7:6] == `CCA_CHVAL_PAGE && araddr[1:0] == 2'b00)
          rd_word = {16'h0000, chval[araddr[5:2]]};
        else if (araddr[7:6] == `CCA_CHCTL_PAGE && araddr[1:0] == 2'b00)
          rd_word = {23'h000000, done[araddr[5:2]], spent[araddr[5:2]],
                     chctl[araddr[5:2]]};
        else
          rd_word = 32'h00000000;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold  <= 1'b0;
      w_hold   <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= `CCA_RESP_OKAY;
      rvalid   <= 1'b0;
      rresp    <= `CCA_RESP_OKAY;
      rdata    <= 32'h00000000;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_hold  <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold  <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_wr)
      begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= mapped(wa) ? `CCA_RESP_OKAY : `CCA_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= mapped(araddr) ? `CCA_RESP_OKAY : `CCA_RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reload0 <= 16'h0000;
      reload1 <= 16'h0000;
      tctrl   <= `CCA_TCTRL_RST;
      status  <= 18'h00000;
      irq_en  <= 18'h00000;
      dbl_en  <= 8'h00;
      pin_out <= 16'h0000;
      spent   <= 16'h0000;
      done    <= 16'h0000;
      for (k = 0; k < 16; k = k + 1)
      begin
        chval[k] <= 16'h0000;
        chctl[k] <= 7'h00;
      end
    end
    else
    begin
      pin_out <= next_pin;
      // set wins over a clear in the same cycle
      status  <= (status & ~clr) | {ovf, cap | hit};
      if (wr_ok && wa == `CCA_RELOAD0)
        reload0 <= merge16(reload0, wdata_q, wstrb_q);
      if (wr_ok && wa == `CCA_RELOAD1)
        reload1 <= merge16(reload1, wdata_q, wstrb_q);
      if (wr_ok && wa == `CCA_TCTRL)
        tctrl <= merge16(tctrl, wdata_q, wstrb_q);
      if (wr_ok && wa == `CCA_IRQ_EN)
        irq_en <= (irq_en & ~wmask[17:0]) | (wdata_q[17:0] & wmask[17:0]);
      if (wr_ok && wa == `CCA_DOUBLE && wstrb_q[0])
        dbl_en <= wdata_q[7:0];
      for (k = 0; k < 16; k = k + 1)
      begin
        if (cap[k])
          chval[k] <= cnt_of(chctl[k][`CCA_CH_TSEL], cnt0, cnt1);
        else if (wr_val && widx == k)
          chval[k] <= merge16(chval[k], wdata_q, wstrb_q);
        if (wr_ctl && widx == k)
        begin
          if (wstrb_q[0])
            chctl[k] <= wdata_q[6:0];
          spent[k] <= 1'b0;
          done[k]  <= 1'b0;
        end
        else if (ovf[chctl[k][`CCA_CH_TSEL]])
          done[k] <= 1'b0;
        // a match in the same cycle wins over any clear
        if (hit[k])
          done[k] <= 1'b1;
        if (hit[k] && chctl[k][`CCA_CH_SINGLE])
          spent[k] <= 1'b1;
      end
    end
  end
endmodule // capture_compare_array

// ### tb/cca_assertions.sv
`timescale 1ns/1ps
module cca_assertions (
  input wire        aclk,
  input wire        aresetn,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_take |=> ##1 bvalid)
    else $error("write not answered");
  AST_RD_ANSWER: assert property (s_rd_take |=> rvalid)
    else $error("read not answered");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_B_DROP: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  AST_R_DROP: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");
  AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken during response");
endmodule // cca_assertions

bind capture_compare_array cca_assertions u_cca_assertions (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready)
);

// ### tb/pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
  input  wire [15:0] ext_drv,
  input  wire [1:0]  ext_cnt,
  input  wire [15:0] pin_out,
  input  wire [15:0] pin_oe,
  output wire [15:0] pin_in,
  output wire [1:0]  count_pin
);
  // wire level: device wins where it drives
  assign pin_in    = (pin_oe & pin_out) | (~pin_oe & ext_drv);
  assign count_pin = ext_cnt;
endmodule // pin_partner

// ### tb/tb_capture_compare_array.sv
`timescale 1ns/1ps
`include "cca_consts.vh"
module tb_capture_compare_array;
  reg         aclk;
  reg         aresetn;
  reg  [7:0]  awaddr;
  reg         awvalid;
  wire        awready;
  reg  [31:0] wdata;
  reg         wvalid;
  wire        wready;
  wire [1:0]  bresp;
  wire        bvalid;
  reg  [7:0]  araddr;
  reg         arvalid;
  wire        arready;
  wire [31:0] rdata;
  wire [1:0]  rresp;
  wire        rvalid;
  wire [15:0] pin_in;
  wire [15:0] pin_out;
  wire [15:0] pin_oe;
  wire [1:0]  count_pin;
  reg  [15:0] ext_drv;
  reg  [1:0]  ext_cnt;
  reg         ext_ovf;
  wire        irq;
  integer     n_errors;
  integer     total_checks;
  integer     cycles;
  reg  [31:0] rd_val;
  reg  [1:0]  rd_resp;

  capture_compare_array u_capture_compare_array (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'h1),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(1'h1), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .count_pin(count_pin),
    .ext_period_ovf(ext_ovf), .irq(irq)
  );
  pin_partner u_pin_partner (
    .ext_drv(ext_drv), .ext_cnt(ext_cnt), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in), .count_pin(count_pin)
  );

  initial
  begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  task test_done;
    begin
      if (n_errors == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  always @(posedge aclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_errors = n_errors + 1;
      test_done;
    end
  end

  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // bready and rready stay high throughout
  // handshakes sampled at the falling edge, where they are settled
  task wr(input [7:0] a, input [31:0] d);
    reg aw_go;
    reg w_go;
    reg b_seen;
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      b_seen = 1'h0;
      while (!b_seen)
      begin
        @(negedge aclk);
        aw_go = awvalid & awready;
        w_go = wvalid & wready;
        b_seen = bvalid;
        @(posedge aclk);
        if (aw_go) awvalid <= 1'h0;
        if (w_go) wvalid <= 1'h0;
      end
    end
  endtask

  task rd(input [7:0] a);
    reg ar_go;
    reg r_seen;
    begin
      araddr <= a;
      arvalid <= 1'h1;
      r_seen = 1'h0;
      while (!r_seen)
      begin
        @(negedge aclk);
        ar_go = arvalid & arready;
        r_seen = rvalid;
        rd_val = rdata;
        rd_resp = rresp;
        @(posedge aclk);
        if (ar_go) arvalid <= 1'h0;
      end
    end
  endtask

  task wait_pin(input integer i, input v, input integer n);
    integer k;
    begin
      k = 0;
      @(negedge aclk);
      while (pin_out[i] !== v && k < n)
      begin
        @(negedge aclk);
        k = k + 1;
      end
      chk("pin_out", {31'h0, v}, {31'h0, pin_out[i]});
      @(posedge aclk);
    end
  endtask

  task t_regs;
    begin
      rd(`CCA_TCTRL);
      chk("tctrl", 32'h77, rd_val);
      rd(8'h3C);
      chk("unmapped", 32'h2, {30'h0, rd_resp});
    end
  endtask

  task t_capture;
    begin
      wr(`CCA_IRQ_EN, 32'h1);
      wr(`CCA_CNT0, 32'h1234);
      wr(8'h80, 32'h9);
      ext_drv[0] <= 1'h1;
      repeat (6) @(posedge aclk);
      rd(8'h40);
      chk("chval0", 32'h1234, rd_val);
      chk("irq", 32'h1, {31'h0, irq});
      wr(`CCA_IRQ_CLR, 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
      wr(`CCA_CNT0, 32'h55);
      ext_drv[0] <= 1'h0;
      repeat (6) @(posedge aclk);
      rd(8'h40);
      chk("chval0", 32'h1234, rd_val);
      wr(8'h80, 32'h19);
      ext_drv[0] <= 1'h1;
      repeat (6) @(posedge aclk);
      rd(8'h40);
      chk("chval0", 32'h55, rd_val);
      wr(`CCA_CNT0, 32'h77);
      wr(8'h80, 32'h11);
      ext_drv[0] <= 1'h0;
      repeat (6) @(posedge aclk);
      rd(8'h40);
      chk("chval0", 32'h77, rd_val);
    end
  endtask

  // ch1 toggle, ch2 set/reset, ch3 single toggle, ch4 irq only
  task t_compare;
    begin
      wr(`CCA_RELOAD0, 32'hFFC0);
      wr(8'h44, 32'hFFE0);
      wr(8'h84, 32'h3);
      wr(8'h48, 32'hFFE0);
      wr(8'h88, 32'h5);
      wr(8'h4C, 32'hFFE0);
      wr(8'h8C, 32'h43);
      wr(8'h50, 32'hFFE0);
      wr(8'h90, 32'h2);
      chk("pin_oe", 32'hE, {27'h0, pin_oe[4:0]});
      wr(`CCA_CNT0, 32'hFFC0);
      wr(`CCA_TCTRL, 32'h70);
      wait_pin(1, 1'h1, 80);
      wait_pin(2, 1'h1, 10);
      wait_pin(3, 1'h1, 10);
      wait_pin(2, 1'h0, 60);
      wait_pin(1, 1'h0, 80);
      repeat (130) @(posedge aclk);
      chk("single", 32'h1, {31'h0, pin_out[3]});
      wr(8'h8C, 32'h43);
      wait_pin(3, 1'h0, 80);
      rd(`CCA_STATUS);
      chk("mode0", 32'h10, rd_val & 32'h10);
      chk("mode0 pin", 32'h0, {31'h0, pin_out[4]});
    end
  endtask

  // timer 1 from count pin, period overflow, staggered prescale
  task t_clocks;
    begin
      wr(`CCA_CNT1, 32'h10);
      wr(`CCA_TCTRL, 32'h67);
      repeat (3)
      begin
        ext_cnt[1] <= 1'h1;
        repeat (4) @(posedge aclk);
        ext_cnt[1] <= 1'h0;
        repeat (4) @(posedge aclk);
      end
      rd(`CCA_CNT1);
      chk("cnt1 pin", 32'h13, rd_val);
      wr(`CCA_TCTRL, 32'h57);
      repeat (2)
      begin
        ext_ovf <= 1'h1;
        @(posedge aclk);
        ext_ovf <= 1'h0;
        repeat (3) @(posedge aclk);
      end
      rd(`CCA_CNT1);
      chk("cnt1 period", 32'h15, rd_val);
      wr(`CCA_CNT1, 32'h0);
      wr(`CCA_TCTRL, 32'h107);
      repeat (80) @(posedge aclk);
      wr(`CCA_TCTRL, 32'h177);
      rd(`CCA_CNT1);
      // 83 running cycles at one tick per eight
      chk("stagger", 32'h1, {31'h0, rd_val >= 32'hA && rd_val <= 32'hB});
    end
  endtask

  // timer 1 stopped; counter writes force matches
  task t_modes;
    reg v1;
    begin
      wr(8'h54, 32'h100);
      wr(8'h94, 32'h24);
      wr(8'h58, 32'h100);
      wr(8'h98, 32'h22);
      wr(`CCA_CNT1, 32'h100);
      wr(`CCA_IRQ_CLR, 32'h60);
      wr(`CCA_CNT1, 32'h100);
      rd(`CCA_STATUS);
      chk("mode2 once", 32'h40, rd_val & 32'h60);
      wr(8'h44, 32'h200);
      wr(8'h84, 32'h23);
      wr(8'h64, 32'h300);
      wr(8'hA4, 32'h23);
      wr(`CCA_DOUBLE, 32'h2);
      chk("pin_oe pair", 32'h1, {30'h0, pin_oe[9], pin_oe[1]});
      v1 = pin_out[1];
      wr(`CCA_CNT1, 32'h200);
      wait_pin(1, ~v1, 4);
      wr(`CCA_CNT1, 32'h300);
      wait_pin(1, v1, 4);
      chk("pin9", 32'h0, {31'h0, pin_out[9]});
    end
  endtask

  initial
  begin
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    aresetn = 1'h0;
    awaddr = 8'h0;
    awvalid = 1'h0;
    wdata = 32'h0;
    wvalid = 1'h0;
    araddr = 8'h0;
    arvalid = 1'h0;
    ext_drv = 16'h0;
    ext_cnt = 2'h0;
    ext_ovf = 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs;
    t_capture;
    t_compare;
    t_clocks;
    t_modes;
    test_done;
  end
endmodule // tb_capture_compare_array
